// ### acc_coeff_reg.sv
// one 24-bit coefficient with serial load and calibration overwrite
module acc_coeff_reg (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic frame_i,
    input wire logic wr_bit_valid_i,
    input wire logic wr_bit_i,
    input wire logic cal_active_i,
    input wire logic cal_load_i,
    input wire logic [23:0] cal_value_i,
    output logic [23:0] value_o
);

    // ==========================================================
    // serial shift and bit count
    logic [23:0] shift;
    logic [4:0] bit_cnt;
    logic take_bit;

    // host bits are ignored while a calibration runs
    assign take_bit = wr_bit_valid_i && !cal_active_i;

    // bits arrive MSB first; count restarts with each frame
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            shift <= acc_pkg::COEF_RESET;
            bit_cnt <= acc_pkg::BIT_CNT_RESET;
        end else if (!frame_i) begin
            bit_cnt <= acc_pkg::BIT_CNT_RESET;
        end else if (take_bit) begin
            shift <= {shift[22:0], wr_bit_i}; // RULE_03
            bit_cnt <= (bit_cnt == acc_pkg::BIT_CNT_LAST) ? acc_pkg::BIT_CNT_RESET : bit_cnt + 5'h01;
        end
    end

    // ==========================================================
    // held value: host commit on 24th bit, calibration overwrites
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            value_o <= acc_pkg::COEF_RESET;
        end else if (cal_load_i) begin
            value_o <= cal_value_i; // RULE_04
        end else if (frame_i && take_bit && bit_cnt == acc_pkg::BIT_CNT_LAST) begin
            value_o <= {shift[22:0], wr_bit_i}; // RULE_12
        end
    end

endmodule : acc_coeff_reg

// ### acc_correction.sv
// correction datapath: self offset, self gain, system offset, doubling,
// system gain, digital gain, clamp and output coding
module acc_correction (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire acc_pkg::acc_ctrl_s ctrl_i,
    input wire logic unipolar_i,
    input wire logic format_offset_i,
    input wire logic raw_valid_i,
    input wire logic [23:0] raw_data_i,
    input wire logic reg_frame_i,
    input wire acc_pkg::acc_sel_e reg_sel_i,
    input wire logic reg_wr_bit_valid_i,
    input wire logic reg_wr_bit_i,
    input wire logic reg_rd_load_i,
    input wire logic reg_rd_shift_i,
    input wire logic cal_active_i,
    input wire logic cal_load_i,
    input wire acc_pkg::acc_sel_e cal_sel_i,
    input wire logic [23:0] cal_value_i,
    output logic result_valid_o,
    output logic [19:0] result_o,
    output logic reg_sdo_o
);

    // ==========================================================
    // coefficient storage
    logic [23:0] coeff [4];

    // four coefficients, indexed by the select code
    for (genvar i = 0; i < 4; i++) begin : g_coeff
        acc_coeff_reg u_coeff (
            .clk_sys_i(clk_sys_i),
            .nrst_i(nrst_i),
            .frame_i(reg_frame_i),
            .wr_bit_valid_i(reg_wr_bit_valid_i && (reg_sel_i == acc_pkg::acc_sel_e'(i))),
            .wr_bit_i(reg_wr_bit_i),
            .cal_active_i(cal_active_i),
            .cal_load_i(cal_load_i && (cal_sel_i == acc_pkg::acc_sel_e'(i))),
            .cal_value_i(cal_value_i),
            .value_o(coeff[i])
        );
    end

    // ==========================================================
    // serial read back, MSB first
    logic [23:0] rd_shift;

    // load a snapshot then shift toward the MSB output
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            rd_shift <= acc_pkg::COEF_RESET;
        end else if (reg_rd_load_i) begin
            rd_shift <= coeff[reg_sel_i]; // RULE_10
        end else if (reg_rd_shift_i) begin
            rd_shift <= {rd_shift[22:0], 1'b0};
        end
    end

    assign reg_sdo_o = rd_shift[23]; // RULE_11

    // ==========================================================
    // stage 1: self-calibration offset
    acc_pkg::acc_stage_s st_self_off;
    logic signed [acc_pkg::DW-1:0] self_off_term;

    assign self_off_term = ctrl_i.self_offset_bypass ? '0 :
        acc_pkg::acc_sext(coeff[acc_pkg::ACC_SEL_SELF_OFF]); // RULE_13

    // first correction applied to the raw sample
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            st_self_off <= '0;
        end else begin
            st_self_off.valid <= raw_valid_i;
            st_self_off.data <= acc_pkg::acc_sext(raw_data_i) - self_off_term; // RULE_14
        end
    end

    // ==========================================================
    // stage 2: self-calibration gain
    acc_pkg::acc_stage_s st_self_gain;

    // scale before any system correction
    acc_gain_mul u_self_gain ( // RULE_15
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .in_i(st_self_off),
        .coef_i(coeff[acc_pkg::ACC_SEL_SELF_GAIN]),
        .bypass_i(ctrl_i.self_gain_bypass),
        .out_o(st_self_gain)
    );

    // ==========================================================
    // stage 3: system offset, then range scale factor
    acc_pkg::acc_stage_s st_sys_off;
    logic signed [acc_pkg::DW-1:0] sys_off_term;
    logic signed [acc_pkg::DW-1:0] sys_off_diff;

    assign sys_off_term = ctrl_i.system_offset_bypass ? '0 :
        acc_pkg::acc_sext(coeff[acc_pkg::ACC_SEL_SYS_OFF]); // RULE_05
    assign sys_off_diff = st_self_gain.data - sys_off_term; // RULE_06

    // unipolar doubles after the offset, bipolar keeps unity
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            st_sys_off <= '0;
        end else begin
            st_sys_off.valid <= st_self_gain.valid;
            st_sys_off.data <= unipolar_i ? (sys_off_diff <<< 1) : sys_off_diff; // RULE_07
        end
    end

    // ==========================================================
    // stage 4: system gain
    acc_pkg::acc_stage_s st_sys_gain;

    // gains to just under two in Q2.22
    acc_gain_mul u_sys_gain ( // RULE_08 RULE_09
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .in_i(st_sys_off),
        .coef_i(coeff[acc_pkg::ACC_SEL_SYS_GAIN]),
        .bypass_i(ctrl_i.system_gain_bypass),
        .out_o(st_sys_gain)
    );

    // ==========================================================
    // stage 5: digital gain, clamp, output coding
    logic signed [acc_pkg::DW-1:0] digital_gain_select_val;
    logic signed [acc_pkg::DW-1:0] out_val;
    logic [19:0] next_result;

    // digital gain sees only fully corrected data
    assign digital_gain_select_val = st_sys_gain.data <<< ctrl_i.digital_gain_select; // RULE_17
    assign out_val = digital_gain_select_val >>> acc_pkg::OUT_SHIFT;

    // clamp to the code range of the selected mode
    always_comb begin
        if (unipolar_i) begin
            if (out_val > $signed({{(acc_pkg::DW - 20){1'b0}}, acc_pkg::UNI_MAX})) begin
                next_result = acc_pkg::UNI_MAX; // RULE_01
            end else if (out_val < 0) begin
                next_result = acc_pkg::UNI_MIN; // RULE_18
            end else begin
                next_result = out_val[19:0];
            end
        end else begin
            if (out_val > $signed({{(acc_pkg::DW - 20){1'b0}}, acc_pkg::BIP_MAX})) begin
                next_result = acc_pkg::BIP_MAX; // RULE_02
            end else if (out_val < $signed({{(acc_pkg::DW - 20){1'b1}}, acc_pkg::BIP_MIN})) begin
                next_result = acc_pkg::BIP_MIN; // RULE_18
            end else begin
                next_result = out_val[19:0];
            end
            // offset binary flips the sign bit so zero lands on midscale
            if (format_offset_i) begin
                next_result = next_result ^ acc_pkg::MID_FLIP; // RULE_02
            end
        end
    end

    // registered result and its strobe
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            result_o <= acc_pkg::RESULT_RESET;
            result_valid_o <= 1'b0;
        end else begin
            result_valid_o <= st_sys_gain.valid;
            if (st_sys_gain.valid) begin
                result_o <= next_result;
            end
        end
    end

endmodule : acc_correction

// ### acc_correction_asserts.sv
// ====
// port checker for the correction datapath
module acc_correction_asserts (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire acc_pkg::acc_ctrl_s ctrl_i,
    input wire logic unipolar_i,
    input wire logic format_offset_i,
    input wire logic raw_valid_i,
    input wire logic [23:0] raw_data_i,
    input wire logic result_valid_o,
    input wire logic [19:0] result_o
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    // sample taken with every coefficient bypassed and unity digital gain
    sequence s_plain;
        raw_valid_i && ctrl_i[4:1] == 4'hf && ctrl_i[7:5] == 3'h0;
    endsequence

    // sample taken bypassed, gain x128, bipolar two's complement
    sequence s_loud;
        raw_valid_i && ctrl_i[4:1] == 4'hf && ctrl_i[7:5] == 3'h7 && !unipolar_i && !format_offset_i;
    endsequence

    AST_LATENCY: assert property (raw_valid_i |-> ##5 result_valid_o)
        else $error("result missing five cycles after a sample");
    AST_NO_SPURIOUS: assert property (result_valid_o |-> $past(raw_valid_i, 5))
        else $error("result without a sample five cycles before");
    AST_TWOS_PASS: assert property (s_plain ##0 (!unipolar_i && !format_offset_i)
        |-> ##5 result_o == $past(raw_data_i[23:4], 5)) else $error("bypassed two's complement code wrong");
    AST_OFFSET_PASS: assert property (s_plain ##0 (!unipolar_i && format_offset_i)
        |-> ##5 result_o == ($past(raw_data_i[23:4], 5) ^ 20'h80000)) else $error("offset binary code wrong");
    AST_UNI_PASS: assert property (s_plain ##0 (unipolar_i && !raw_data_i[23])
        |-> ##5 result_o == $past(raw_data_i[22:3], 5)) else $error("unipolar code wrong");
    AST_UNI_FLOOR: assert property (s_plain ##0 (unipolar_i && raw_data_i[23])
        |-> ##5 result_o == 20'h00000) else $error("unipolar negative not clamped to zero");
    AST_TOP_CLAMP: assert property (s_loud ##0 (raw_data_i == 24'h7fffff)
        |-> ##5 result_o == 20'h7ffff) else $error("positive overrange not clamped");
    AST_BOTTOM_CLAMP: assert property (s_loud ##0 (raw_data_i[23:20] == 4'h8)
        |-> ##5 result_o == 20'h80000) else $error("negative overrange not clamped");
endmodule : acc_correction_asserts

bind acc_correction acc_correction_asserts u_asserts (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ctrl_i(ctrl_i),
    .unipolar_i(unipolar_i), .format_offset_i(format_offset_i), .raw_valid_i(raw_valid_i),
    .raw_data_i(raw_data_i), .result_valid_o(result_valid_o), .result_o(result_o));

// ### acc_gain_mul.sv
// registered multiply by a signed Q2.22 gain coefficient
module acc_gain_mul (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire acc_pkg::acc_stage_s in_i,
    input wire logic [23:0] coef_i,
    input wire logic bypass_i,
    output acc_pkg::acc_stage_s out_o
);

    // ==========================================================
    // product scaled back by the fraction width
    logic signed [acc_pkg::PROD_W-1:0] data_ext;
    logic signed [acc_pkg::PROD_W-1:0] coef_ext;
    logic signed [acc_pkg::PROD_W-1:0] prod;
    logic signed [acc_pkg::PROD_W-1:0] scaled;

    // both operands sign extended to product width so nothing is padded silently
    assign data_ext = {{(acc_pkg::PROD_W - acc_pkg::DW){in_i.data[acc_pkg::DW-1]}}, in_i.data};
    assign coef_ext = {{(acc_pkg::PROD_W - acc_pkg::COEF_W){coef_i[acc_pkg::COEF_W-1]}}, coef_i};
    assign prod = data_ext * coef_ext; // RULE_19
    assign scaled = prod >>> acc_pkg::GAIN_FRAC;

    // bypassed coefficient passes the sample untouched
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            out_o <= '0;
        end else begin
            out_o.valid <= in_i.valid;
            out_o.data <= bypass_i ? in_i.data : scaled[acc_pkg::DW-1:0]; // RULE_16
        end
    end

endmodule : acc_gain_mul

// ### acc_host_model.sv
// ====
// host side of the serial coefficient port
module acc_host_model (
    input wire logic clk_i,
    output logic frame_o,
    output acc_pkg::acc_sel_e sel_o,
    output logic bit_valid_o,
    output logic bit_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle port at time zero
    initial begin
        frame_o = 1'b0;
        sel_o = acc_pkg::ACC_SEL_SYS_OFF;
        bit_valid_o = 1'b0;
        bit_o = 1'b0;
    end

    // one 24-bit word, idle gap cycles between bits, data line scrambled when idle
    task automatic write(input acc_pkg::acc_sel_e sel, input logic [23:0] w, input int gap);
        @(posedge clk_i) #1;
        frame_o = 1'b1;
        sel_o = sel;
        for (int i = 23; i >= 0; i--) begin
            bit_valid_o = 1'b1;
            bit_o = w[i];
            @(posedge clk_i) #1;
            // back to back bits keep the strobe up; drop it only for a gap or after the last bit
            if (gap > 0 || i == 0) begin
                bit_valid_o = 1'b0;
                bit_o = ~bit_o;
            end
            repeat (gap) @(posedge clk_i) #1;
        end
        frame_o = 1'b0;
    endtask : write
endmodule : acc_host_model

// ### acc_pkg.sv
// What this block does
// RULE_01: unipolar results are straight binary, zero gives 0x00000, saturating at top code.
// RULE_02: bipolar zero gives 0x80000 offset binary or zero two's complement, clamped.
// RULE_03: system offset coefficient is a 24-bit two's complement register, shifted MSB first.
// RULE_04: system coefficients hold until host rewrite or system calibration overwrites them.
// RULE_05: system offset is subtracted only while its bypass bit is 0.
// RULE_06: system offset follows both self corrections and precedes system gain.
// RULE_07: system offset is subtracted before the unipolar doubling scale factor.
// RULE_08: system gain multiplies the offset-corrected result only while its bypass is 0.
// RULE_09: system gain scales by factors up to two.
// RULE_10: system gain coefficient is a 24-bit two's complement register, MSB first.
// RULE_11: self offset coefficient is a 24-bit two's complement register, MSB first.
// RULE_12: self offset holds until host rewrite or self calibration overwrites it.
// RULE_13: self offset is subtracted only while its bypass bit is 0.
// RULE_14: self offset comes first, before self gain, system corrections and doubling.
// RULE_15: self gain scales the self-offset-corrected result while its bypass is 0.
// RULE_16: a bypass bit at 1 removes that coefficient from the result.
// RULE_17: digital gain is applied only after all calibration corrections.
// RULE_18: out-of-range results clamp to minimum or maximum code, never wrap.
// RULE_19: gain coefficients are signed Q2.22, 0x400000 is unity, maximum just under two.
package acc_pkg;

    // ==========================================================
    // widths and fixed point
    localparam int COEF_W = 24;
    localparam int DW = 40;
    localparam int OUT_W = 20;
    localparam int GAIN_FRAC = 22;
    localparam int OUT_SHIFT = 4;
    localparam int PROD_W = DW + COEF_W;

    // ==========================================================
    // reset values and codes
    localparam logic [23:0] COEF_RESET = 24'h000000;
    localparam logic [4:0] BIT_CNT_RESET = 5'h00;
    localparam logic [4:0] BIT_CNT_LAST = 5'h17;
    localparam logic [19:0] RESULT_RESET = 20'h00000;
    localparam logic [19:0] UNI_MAX = 20'hfffff;
    localparam logic [19:0] UNI_MIN = 20'h00000;
    localparam logic [19:0] BIP_MAX = 20'h7ffff;
    localparam logic [19:0] BIP_MIN = 20'h80000;
    localparam logic [19:0] MID_FLIP = 20'h80000;

    // ==========================================================
    // coefficient select
    typedef enum logic [1:0] {
        ACC_SEL_SYS_OFF,
        ACC_SEL_SYS_GAIN,
        ACC_SEL_SELF_OFF,
        ACC_SEL_SELF_GAIN
    } acc_sel_e;

    // calibration control layout, bit 7 down to bit 0
    typedef struct packed {
        logic [2:0] digital_gain_select;
        logic system_gain_bypass;
        logic system_offset_bypass;
        logic self_gain_bypass;
        logic self_offset_bypass;
        logic reserved;
    } acc_ctrl_s;

    // one pipeline stage of the datapath
    typedef struct packed {
        logic valid;
        logic signed [DW-1:0] data;
    } acc_stage_s;

    // sign extend a 24-bit value to datapath width
    function automatic logic signed [DW-1:0] acc_sext(input logic [COEF_W-1:0] v);
        acc_sext = {{(DW - COEF_W){v[COEF_W-1]}}, v};
    endfunction : acc_sext

endpackage : acc_pkg

// ### adc_calibration_correction_test.sv
module adc_calibration_correction_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [23:0] BND [4] = '{24'h000000, 24'h7fffff, 24'h800000, 24'h000010};
    logic clk_sys_i, nrst_i, raw_valid_i, unipolar_i, format_offset_i, rd_load, rd_shift, cal_active, cal_load;
    logic frame, bv, wb, result_valid_o, reg_sdo_o;
    logic [23:0] raw_data_i, cal_value;
    logic [19:0] result_o;
    logic [23:0] cf [4];
    logic [19:0] exp_q [$];
    acc_pkg::acc_ctrl_s ctrl_i;
    acc_pkg::acc_sel_e rsel, cal_sel, hsel;
    int failures, n_checks, cyc;

    acc_host_model host (.clk_i(clk_sys_i), .frame_o(frame), .sel_o(hsel), .bit_valid_o(bv), .bit_o(wb));
    acc_correction dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ctrl_i(ctrl_i), .unipolar_i(unipolar_i),
        .format_offset_i(format_offset_i), .raw_valid_i(raw_valid_i), .raw_data_i(raw_data_i),
        .reg_frame_i(frame), .reg_sel_i(acc_pkg::acc_sel_e'(frame ? hsel : rsel)), .reg_wr_bit_valid_i(bv),
        .reg_wr_bit_i(wb),
        .reg_rd_load_i(rd_load), .reg_rd_shift_i(rd_shift), .cal_active_i(cal_active), .cal_load_i(cal_load),
        .cal_sel_i(cal_sel), .cal_value_i(cal_value), .result_valid_o(result_valid_o), .result_o(result_o),
        .reg_sdo_o(reg_sdo_o));

    // ====
    // checking and closing
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wrap_up;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    function automatic logic signed [63:0] sx(input logic [23:0] v);
        sx = {{40{v[23]}}, v};
    endfunction : sx

    // reference chain in documented order
    function automatic logic [19:0] model(input logic [23:0] raw);
        logic signed [63:0] x;
        x = sx(raw);
        if (!ctrl_i.self_offset_bypass) x = x - sx(cf[2]);
        if (!ctrl_i.self_gain_bypass) x = (x * sx(cf[3])) >>> 22;
        if (!ctrl_i.system_offset_bypass) x = x - sx(cf[0]);
        if (unipolar_i) x = x * 2;
        if (!ctrl_i.system_gain_bypass) x = (x * sx(cf[1])) >>> 22;
        x = (x <<< ctrl_i.digital_gain_select) >>> 4;
        if (unipolar_i) x = (x < 0) ? 64'sd0 : (x > 64'sd1048575 ? 64'sd1048575 : x);
        else x = (x < -64'sd524288) ? -64'sd524288 : (x > 64'sd524287 ? 64'sd524287 : x);
        model = x[19:0] ^ ((!unipolar_i && format_offset_i) ? 20'h80000 : 20'h00000);
    endfunction : model

    task automatic send(input logic [23:0] r);
        raw_valid_i = 1'b1;
        raw_data_i = r;
        exp_q.push_back(model(r));
        @(posedge clk_sys_i) #1;
    endtask : send

    task automatic rd(input int s, output logic [23:0] v);
        rsel = acc_pkg::acc_sel_e'(s);
        rd_load = 1'b1;
        @(posedge clk_sys_i) #1;
        rd_load = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            v[i] = reg_sdo_o;
            rd_shift = 1'b1;
            @(posedge clk_sys_i) #1;
        end
        rd_shift = 1'b0;
    endtask : rd

    // clock
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    // result watcher against the oldest note
    always @(posedge clk_sys_i) begin
        #2;
        if (result_valid_o === 1'b1) begin
            chk("result", {4'h0, result_o}, exp_q.size() ? {4'h0, exp_q.pop_front()} : 24'hx);
        end
    end

    // hang guard
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            wrap_up();
        end
    end

    // ====
    // main sequence
    initial begin
        logic [23:0] v;
        void'($urandom(82774));
        {nrst_i, raw_valid_i, unipolar_i, format_offset_i, rd_load, rd_shift, cal_active, cal_load} = 8'h00;
        raw_data_i = 24'h000000;
        cal_value = 24'h000000;
        ctrl_i = 8'h1e;
        rsel = acc_pkg::ACC_SEL_SYS_OFF;
        cal_sel = acc_pkg::ACC_SEL_SYS_OFF;
        cf = '{default: 24'h000000};
        repeat (12) @(posedge clk_sys_i);
        #1 nrst_i = 1'b1;
        for (int s = 0; s < 4; s++) begin
            rd(s, v);
            chk("coef_reset", v, 24'h000000);
        end
        for (int md = 0; md < 3; md++) begin
            for (int s = 0; s < 4; s++) begin
                if (s[0]) cf[s] = 24'($urandom_range(24'h7fffff, 24'h200000));
                else cf[s] = 24'($urandom_range(24'h1fffff, 24'h000000)) - 24'h100000;
                host.write(acc_pkg::acc_sel_e'(s), cf[s], md);
                rd(s, v);
                chk("coef_readback", v, cf[s]);
            end
            unipolar_i = (md == 2);
            format_offset_i = (md == 1);
            for (int k = 0; k < 32; k++) begin
                ctrl_i = {k[4] ? 3'h7 : 3'(k + 1), k[3:0], 1'b0};
                for (int j = 0; j < 8; j++) begin
                    send(j < 4 ? BND[j] : 24'($urandom) & (unipolar_i ? 24'h7fffff : 24'hffffff));
                end
                raw_valid_i = 1'b0;
                repeat (7) @(posedge clk_sys_i) #1;
            end
        end
        // calibration overwrite wins, host bits ignored while it runs
        for (int s = 0; s < 4; s++) begin
            cal_sel = acc_pkg::acc_sel_e'(s);
            cal_value = 24'(s * 24'h111111 + 24'h0a0a0a);
            cal_load = 1'b1;
            @(posedge clk_sys_i) #1;
            cal_load = 1'b0;
            cal_active = 1'b1;
            host.write(acc_pkg::acc_sel_e'(s), 24'h123456, 0);
            cal_active = 1'b0;
            cf[s] = cal_value;
            rd(s, v);
            chk("cal_overwrite", v, cal_value);
        end
        unipolar_i = 1'b0;
        ctrl_i = 8'h20;
        for (int j = 0; j < 8; j++) send(24'($urandom));
        raw_valid_i = 1'b0;
        repeat (8) @(posedge clk_sys_i) #1;
        // every noted sample must have produced its result
        chk("results_left", 24'(exp_q.size()), 24'h000000);
        wrap_up();
    end
endmodule : adc_calibration_correction_test
